/* File: include/iefb_consts.svh */
// Offsets, field positions, reset values and masks of the interrupt enable and flag bank
// Summary of operation
// (R1) Priority on: global/high enable gates all; hardware clears it on high-priority entry.
// (R2) Priority off: global enable gates all; hardware clears it on any interrupt entry.
// (R3) Priority on: low enable gates low priority; hardware clears it on low entry.
// (R4) Priority off: low enable bit gates only the peripheral sources.
// (R5) Priority-levels bit selects one-level or two-level meaning of both enables.
// (R6) Each external edge select bit: one means rising edge, zero means falling edge.
// (R7) Flags set on their condition whatever the enables, so software may poll.
// (R8) Software should clear a flag before setting its enable bit.
// (R9) Timer0 overflow flag sets on overflow and stays set until software clears it.
// (R10) Pin-change flag is read-only and follows the pending pin-change bank.
// (R11) External flags set on the selected edge and stay software writable.
// (R12) Each external interrupt takes its pin through a separate pin-select register; here two four-bit fields share each of the two pin-select registers.
// (R13) Priority off: sources of flag register 0 are never gated by the peripheral enable.
// (R14) Oscillator-fail flag sets on clock failure with fallback; software clears it.
// (R15) Clock-switch flag sets when the new oscillator is ready; software clears it.
// (R16) Clock-switch-ready never wakes the device from sleep.
// (R17) ADC threshold flag sets on threshold event; software clears it.
// (R18) ADC done flag sets on conversion end; held until software clears it.
// (R19) Voltage detect flag sets when the detector reports its event.
// (R20) Zero-cross flag sets on any detector output change; software clears it.
// (R21) Each comparator flag sets on its output change; software clears it.
// (R22) UART receive flags are read-only and show a full receive buffer.
// (R23) UART transmit flags are read-only and show an empty transmit buffer.
// (R24) Bus-collision flags set on master collision; software clears them.
// (R25) Serial port flags set on transfer completion; software clears them.
// (R26) Writable flags hold until a zero is written; a hardware set wins.
`ifndef IEFB_CONSTS_SVH
`define IEFB_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define IEFB_ADDR_W          12
`define IEFB_OFF_FLAGS0      12'hE33
`define IEFB_OFF_FLAGS1      12'hE34
`define IEFB_OFF_FLAGS2      12'hE35
`define IEFB_OFF_FLAGS3      12'hE36
`define IEFB_OFF_CONTROL     12'hFF2
`define IEFB_OFF_PINSEL_LO   12'hF00
`define IEFB_OFF_PINSEL_HI   12'hF01

// ****************************************
// Fields, masks and reset values
// ****************************************
`define IEFB_CONTROL_RST     8'h07
`define IEFB_BIT_GLOBAL_EN   7
`define IEFB_BIT_LOW_EN      6
`define IEFB_BIT_PRIO_ON     5
`define IEFB_BIT_PINCHG      4
`define IEFB_F0_SW_MASK      8'h2F
`define IEFB_F1_SW_MASK      8'hC3
`define IEFB_F2_SW_MASK      8'hC7
`define IEFB_F3_SW_MASK      8'h0F
`define IEFB_SRC_CSW         14
`define IEFB_PINSEL_RST      16'h3210

`endif

/* File: include/iefb_pkg.sv */
// Types shared by the interrupt enable and flag bank
package iefb_pkg;

    // Register port request from the core
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } iefb_bus_type;

    // Event inputs from the peripherals
    typedef struct packed {
        logic        timer0_ovf;
        logic [15:0] ext_pins;
        logic        pin_change_pending;
        logic        osc_fail;
        logic        clock_switch_ready;
        logic        adc_threshold;
        logic        adc_done;
        logic        voltage_detect;
        logic        zero_cross_out;
        logic [2:0]  comparator_out;
        logic [1:0]  uart_rx_full;
        logic [1:0]  uart_tx_empty;
        logic [1:0]  bus_collision;
        logic [1:0]  serial_port_done;
    } iefb_event_type;

    // Interrupt entry report from the core
    typedef struct packed {
        logic taken;
        logic taken_high;
    } iefb_take_type;

    // Requests towards the core
    typedef struct packed {
        logic req_high;
        logic req_low;
        logic wake;
    } iefb_req_type;

    // All state of the bank
    typedef struct packed {
        logic        global_high_enable;
        logic        periph_low_enable;
        logic        priority_levels_on;
        logic [3:0]  ext_edge_select;
        logic [7:0]  irq_flags_0;
        logic [7:0]  irq_flags_1;
        logic [7:0]  irq_flags_2;
        logic [7:0]  irq_flags_3;
        logic [15:0] ext_pin_select;
        logic [3:0]  ext_prev;
        logic        zero_cross_prev;
        logic [2:0]  comparator_prev;
        logic        primed;
        logic [7:0]  rdata;
    } iefb_state_type;

endpackage

/* File: verification/iefb_core_model.sv */
// Processor core model: takes pending interrupt requests after a chosen lag
`timescale 1ns/100ps

module iefb_core_model (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire iefb_pkg::iefb_req_type req,
    input  wire logic                   ack_on,
    input  wire logic [3:0]             lag,
    output iefb_pkg::iefb_take_type     take
);
    import iefb_pkg::*;

    logic [3:0] wait_q;

    // ****************************************
    // Entry report
    // ****************************************
    // One-cycle entry pulse; the priority qualifier is junk outside an entry
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            take   <= '0;
            wait_q <= 4'h0;
        end else begin
            take.taken      <= 1'b0;
            take.taken_high <= ~take.taken_high;
            if (ack_on && (req.req_high || req.req_low) && !take.taken) begin
                if (wait_q == lag) begin
                    take.taken      <= 1'b1;
                    take.taken_high <= req.req_high;
                    wait_q          <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule

/* File: verification/iefb_top_test.sv */
// Self-checking bench for the interrupt enable and flag bank
`timescale 1ns/100ps
`include "iefb_consts.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module iefb_top_test;
    import iefb_pkg::*;

    logic                clk_sys;
    logic                reset_n;
    logic                clk_en;
    iefb_bus_type        bus;
    logic [7:0]          rdata;
    iefb_event_type      evt;
    logic [31:0]         src_enable;
    logic [31:0]         src_high_prio;
    iefb_take_type       take;
    iefb_req_type        req;
    logic [9:0]          pulse_src;
    logic [15:0]         pins;
    logic                pc_pend;
    logic                zc;
    logic [2:0]          cmp;
    logic [1:0]          rx;
    logic [1:0]          tx;
    logic                ack_on;
    logic [3:0]          lag;
    logic [7:0]          rd_v;
    int                  fails;
    int                  check_count;

    // Register and bit that each pulse source lands in
    localparam logic [11:0] src_off [10] = '{`IEFB_OFF_FLAGS0, `IEFB_OFF_FLAGS1,
        `IEFB_OFF_FLAGS1, `IEFB_OFF_FLAGS1, `IEFB_OFF_FLAGS1, `IEFB_OFF_FLAGS2,
        `IEFB_OFF_FLAGS3, `IEFB_OFF_FLAGS3, `IEFB_OFF_FLAGS3, `IEFB_OFF_FLAGS3};
    localparam logic [7:0] src_bit [10] = '{8'h20, 8'h80, 8'h40, 8'h02, 8'h01, 8'h80,
        8'h02, 8'h08, 8'h01, 8'h04};

    // Peripheral event bundle
    assign evt = '{timer0_ovf: pulse_src[0], ext_pins: pins, pin_change_pending: pc_pend,
        osc_fail: pulse_src[1], clock_switch_ready: pulse_src[2], adc_threshold: pulse_src[3],
        adc_done: pulse_src[4], voltage_detect: pulse_src[5], zero_cross_out: zc,
        comparator_out: cmp, uart_rx_full: rx, uart_tx_empty: tx,
        bus_collision: pulse_src[7:6], serial_port_done: pulse_src[9:8]};

    iefb_top iefb_top_i (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .clk_en        (clk_en),
        .bus           (bus),
        .rdata         (rdata),
        .evt           (evt),
        .src_enable    (src_enable),
        .src_high_prio (src_high_prio),
        .take          (take),
        .req           (req)
    );

    iefb_core_model iefb_core_model_i (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .req     (req),
        .ack_on  (ack_on),
        .lag     (lag),
        .take    (take)
    );

    // ****************************************
    // Bus and event tasks
    // ****************************************
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        rd_v = rdata;
        `CHK(what, exp, rd_v)
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys);
        pulse_src[i] <= 1'b1;
        @(posedge clk_sys);
        pulse_src[i] <= 1'b0;
    endtask

    task automatic summarize;
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        summarize();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        bus = '0;
        pulse_src = '0;
        pins = 16'h000F;
        {pc_pend, zc, cmp, rx, tx} = '0;
        src_enable = 32'h0;
        src_high_prio = 32'h0;
        ack_on = 1'b0;
        lag = 4'h0;
        fails = 0;
        check_count = 0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Reset values, access kinds, unmapped place, frozen strobe
        rd_chk("control reset", `IEFB_OFF_CONTROL, 8'h07);
        for (int i = 0; i < 4; i++) begin
            rd_chk("flags reset", 12'(`IEFB_OFF_FLAGS0 + i), 8'h00);
        end
        rd_chk("pin select lo", `IEFB_OFF_PINSEL_LO, 8'h10);
        rd_chk("pin select hi", `IEFB_OFF_PINSEL_HI, 8'h32);
        rd_chk("unmapped", 12'hE37, 8'h00);
        wr_reg(`IEFB_OFF_CONTROL, 8'hFF);
        rd_chk("control rw", `IEFB_OFF_CONTROL, 8'hEF);
        @(posedge clk_sys) clk_en <= 1'b0;
        wr_reg(`IEFB_OFF_CONTROL, 8'h00);
        @(posedge clk_sys) clk_en <= 1'b1;
        rd_chk("frozen write", `IEFB_OFF_CONTROL, 8'hEF);
        wr_reg(`IEFB_OFF_CONTROL, 8'h07);
        // Each pulse source sets its flag with all enables off, holds, clears
        for (int i = 0; i < 10; i++) begin
            pulse(i);
            repeat (3) @(posedge clk_sys);
            rd_chk("flag held", src_off[i], src_bit[i]);
            wr_reg(src_off[i], 8'h00);
            rd_chk("flag cleared", src_off[i], 8'h00);
        end
        // Hardware set meets a software clear in the same cycle
        @(posedge clk_sys);
        bus.addr <= `IEFB_OFF_FLAGS0;
        bus.wdata <= 8'h00;
        bus.wr <= 1'b1;
        pulse_src[0] <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        pulse_src[0] <= 1'b0;
        rd_chk("set beats clear", `IEFB_OFF_FLAGS0, 8'h20);
        // External edges on reselected pins, old pins moving the other way
        wr_reg(`IEFB_OFF_PINSEL_LO, 8'h98);
        wr_reg(`IEFB_OFF_PINSEL_HI, 8'hBA);
        wr_reg(`IEFB_OFF_CONTROL, 8'h05);
        wr_reg(`IEFB_OFF_FLAGS0, 8'h00);
        @(posedge clk_sys) pins <= 16'h0F00;
        rd_chk("rising edges", `IEFB_OFF_FLAGS0, 8'h05);
        wr_reg(`IEFB_OFF_FLAGS0, 8'h00);
        @(posedge clk_sys) pins <= 16'h000F;
        rd_chk("falling edges", `IEFB_OFF_FLAGS0, 8'h0A);
        wr_reg(`IEFB_OFF_FLAGS0, 8'h00);
        // Change detectors fire on either direction
        @(posedge clk_sys) {zc, cmp} <= 4'hD;
        rd_chk("detector rise", `IEFB_OFF_FLAGS2, 8'h45);
        wr_reg(`IEFB_OFF_FLAGS2, 8'h00);
        @(posedge clk_sys) {zc, cmp} <= 4'h1;
        rd_chk("detector fall", `IEFB_OFF_FLAGS2, 8'h44);
        wr_reg(`IEFB_OFF_FLAGS2, 8'h00);
        // Read-only level flags ignore writes and follow their sources
        wr_reg(`IEFB_OFF_FLAGS3, 8'hF0);
        rd_chk("uart bits ro", `IEFB_OFF_FLAGS3, 8'h00);
        @(posedge clk_sys) {pc_pend, rx, tx} <= 5'b11101;
        wr_reg(`IEFB_OFF_FLAGS0, 8'h00);
        wr_reg(`IEFB_OFF_FLAGS3, 8'h00);
        rd_chk("pin change ro", `IEFB_OFF_FLAGS0, 8'h10);
        rd_chk("uart levels", `IEFB_OFF_FLAGS3, 8'hB0);
        @(posedge clk_sys) {pc_pend, rx, tx} <= 5'b00000;
        rd_chk("pin change gone", `IEFB_OFF_FLAGS0, 8'h00);
        // One level: slow core entry clears the global enable
        @(posedge clk_sys) src_enable <= 32'h0000_4120;
        lag <= 4'h3;
        ack_on <= 1'b1;
        wr_reg(`IEFB_OFF_FLAGS1, 8'h00);
        wr_reg(`IEFB_OFF_CONTROL, 8'h87);
        pulse(2);
        #1 `CHK("switch no wake", 1'b0, req.wake)
        pulse(4);
        #1 `CHK("periph gated", 1'b0, req.req_high)
        `CHK("periph wake", 1'b1, req.wake)
        pulse(0);
        #1 `CHK("timer0 ungated", 1'b1, req.req_high)
        repeat (8) @(posedge clk_sys);
        rd_chk("global cleared", `IEFB_OFF_CONTROL, 8'h07);
        // Two levels: prompt core entries clear only their own enable
        @(posedge clk_sys) ack_on <= 1'b0;
        src_high_prio <= 32'h0000_0020;
        lag <= 4'h0;
        wr_reg(`IEFB_OFF_FLAGS0, 8'h00);
        wr_reg(`IEFB_OFF_FLAGS1, 8'h00);
        wr_reg(`IEFB_OFF_CONTROL, 8'hE7);
        pulse(4);
        #1 `CHK("low request", 1'b1, req.req_low)
        `CHK("no high request", 1'b0, req.req_high)
        @(posedge clk_sys) ack_on <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk("low entry", `IEFB_OFF_CONTROL, 8'hA7);
        pulse(0);
        #1 `CHK("high request", 1'b1, req.req_high)
        repeat (4) @(posedge clk_sys);
        rd_chk("high entry", `IEFB_OFF_CONTROL, 8'h27);
        summarize();
    end
endmodule

/* File: verilog/iefb_top.sv */
// Interrupt enable and flag bank: control register, flag registers 0 to 3, request logic
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "iefb_consts.svh"

module iefb_top (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire iefb_pkg::iefb_bus_type  bus,
    output logic [7:0]                   rdata,
    input  wire iefb_pkg::iefb_event_type evt,
    input  wire logic [31:0]             src_enable,
    input  wire logic [31:0]             src_high_prio,
    input  wire iefb_pkg::iefb_take_type take,
    output iefb_pkg::iefb_req_type       req
);
    import iefb_pkg::*;

    // ****************************************
    // Functions
    // ****************************************

    // Selected edge seen between two samples
    function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
        edge_hit = rising ? (!prev && cur) : (prev && !cur);
    endfunction

    // Pick one of sixteen pins by a four-bit index
    function automatic logic pin_pick(input logic [15:0] pins, input logic [3:0] idx);
        pin_pick = pins[idx];
    endfunction

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n_q;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_sync_q[1];

    // ****************************************
    // Event decoding
    // ****************************************
    iefb_state_type s_q;
    iefb_state_type s_d;
    logic [3:0]     ext_now;
    logic [3:0]     ext_hit;
    logic           zc_hit;
    logic [2:0]     cmp_hit;
    logic [7:0]     set0;
    logic [7:0]     set1;
    logic [7:0]     set2;
    logic [7:0]     set3;
    logic [7:0]     flags0_view;
    logic [7:0]     flags3_view;
    logic [31:0]    all_flags;
    logic [31:0]    pending;
    logic           wr0;
    logic           wr1;
    logic           wr2;
    logic           wr3;

    // Route each external interrupt through its pin select and find edges
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ext_now[i] = pin_pick(evt.ext_pins, s_q.ext_pin_select[4*i +: 4]); // R12
            ext_hit[i] = s_q.primed &&
                         edge_hit(s_q.ext_prev[i], ext_now[i], s_q.ext_edge_select[i]); // R6
        end
    end

    // Output changes of the zero-cross detector and the comparators
    assign zc_hit  = s_q.primed && (s_q.zero_cross_prev != evt.zero_cross_out); // R20
    assign cmp_hit = s_q.primed ? (s_q.comparator_prev ^ evt.comparator_out) : 3'h0; // R21

    // Hardware set terms, independent of any enable
    assign set0 = {2'h0, evt.timer0_ovf, 1'b0, ext_hit}; // R7 R9 R11
    assign set1 = {evt.osc_fail, evt.clock_switch_ready, 4'h0,
                   evt.adc_threshold, evt.adc_done}; // R14 R15 R17 R18
    assign set2 = {evt.voltage_detect, zc_hit, 3'h0, cmp_hit}; // R19 R20 R21
    assign set3 = {4'h0, evt.bus_collision[1], evt.serial_port_done[1],
                   evt.bus_collision[0], evt.serial_port_done[0]}; // R24 R25

    // Read-only bits follow their sources directly
    assign flags0_view = {s_q.irq_flags_0[7:5], evt.pin_change_pending,
                          s_q.irq_flags_0[3:0]}; // R10
    assign flags3_view = {evt.uart_rx_full[1], evt.uart_tx_empty[1],
                          evt.uart_rx_full[0], evt.uart_tx_empty[0],
                          s_q.irq_flags_3[3:0]}; // R22 R23
    assign all_flags = {flags3_view, s_q.irq_flags_2, s_q.irq_flags_1, flags0_view};
    assign pending   = all_flags & src_enable;

    // Register write strobes
    assign wr0 = bus.wr && (bus.addr == `IEFB_OFF_FLAGS0);
    assign wr1 = bus.wr && (bus.addr == `IEFB_OFF_FLAGS1);
    assign wr2 = bus.wr && (bus.addr == `IEFB_OFF_FLAGS2);
    assign wr3 = bus.wr && (bus.addr == `IEFB_OFF_FLAGS3);

    // ****************************************
    // Request logic
    // ****************************************
    logic any_f0;
    logic any_periph;
    logic any_high;
    logic any_low;

    // Flag register 0 bypasses the peripheral enable when priority levels are off
    assign any_f0     = |pending[7:0]; // R13
    assign any_periph = |pending[31:8];
    assign any_high   = |(pending & src_high_prio);
    assign any_low    = |(pending & ~src_high_prio);

    // Requests follow the one-level or two-level meaning of the enables
    always_comb begin
        if (s_q.priority_levels_on) begin // R5
            req.req_high = s_q.global_high_enable && any_high; // R1
            req.req_low  = s_q.global_high_enable && s_q.periph_low_enable && any_low; // R3
        end else begin
            req.req_high = s_q.global_high_enable &&
                           (any_f0 || (s_q.periph_low_enable && any_periph)); // R2 R4
            req.req_low  = 1'b0;
        end
        // Clock-switch-ready cannot end sleep
        req.wake = |(pending & ~(32'h1 << `IEFB_SRC_CSW)); // R16
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // Edge history; first cycle after reset only loads it
        s_d.primed          = 1'b1;
        s_d.ext_prev        = ext_now;
        s_d.zero_cross_prev = evt.zero_cross_out;
        s_d.comparator_prev = evt.comparator_out;
        // Control register and pin select writes
        if (bus.wr && (bus.addr == `IEFB_OFF_CONTROL)) begin
            s_d.global_high_enable = bus.wdata[`IEFB_BIT_GLOBAL_EN];
            s_d.periph_low_enable  = bus.wdata[`IEFB_BIT_LOW_EN];
            s_d.priority_levels_on = bus.wdata[`IEFB_BIT_PRIO_ON];
            s_d.ext_edge_select    = bus.wdata[3:0];
        end
        if (bus.wr && (bus.addr == `IEFB_OFF_PINSEL_LO)) begin
            s_d.ext_pin_select[7:0] = bus.wdata;
        end
        if (bus.wr && (bus.addr == `IEFB_OFF_PINSEL_HI)) begin
            s_d.ext_pin_select[15:8] = bus.wdata;
        end
        // Hardware clear of the enables on interrupt entry
        if (take.taken) begin
            if (!s_q.priority_levels_on) begin
                s_d.global_high_enable = 1'b0; // R2
            end else if (take.taken_high) begin
                s_d.global_high_enable = 1'b0; // R1
            end else begin
                s_d.periph_low_enable = 1'b0; // R3
            end
        end
        // Flags: software value then hardware set on top
        s_d.irq_flags_0 = ((wr0 ? bus.wdata : s_q.irq_flags_0) | set0) & `IEFB_F0_SW_MASK; // R26
        s_d.irq_flags_1 = ((wr1 ? bus.wdata : s_q.irq_flags_1) | set1) & `IEFB_F1_SW_MASK; // R26
        s_d.irq_flags_2 = ((wr2 ? bus.wdata : s_q.irq_flags_2) | set2) & `IEFB_F2_SW_MASK; // R26
        s_d.irq_flags_3 = ((wr3 ? bus.wdata : s_q.irq_flags_3) | set3) & `IEFB_F3_SW_MASK; // R26
        // Read data for the following cycle; unmapped reads return zero
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                `IEFB_OFF_FLAGS0:    s_d.rdata = flags0_view;
                `IEFB_OFF_FLAGS1:    s_d.rdata = s_q.irq_flags_1;
                `IEFB_OFF_FLAGS2:    s_d.rdata = s_q.irq_flags_2;
                `IEFB_OFF_FLAGS3:    s_d.rdata = flags3_view;
                `IEFB_OFF_CONTROL:   s_d.rdata = {s_q.global_high_enable, s_q.periph_low_enable,
                                                  s_q.priority_levels_on, 1'b0,
                                                  s_q.ext_edge_select};
                `IEFB_OFF_PINSEL_LO: s_d.rdata = s_q.ext_pin_select[7:0];
                `IEFB_OFF_PINSEL_HI: s_d.rdata = s_q.ext_pin_select[15:8];
                default:             s_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q                    <= '0;
            s_q.ext_edge_select    <= 4'(`IEFB_CONTROL_RST); // Edge select field only
            s_q.ext_pin_select     <= `IEFB_PINSEL_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_q);

    sequence s_take_plain;
        clk_en && take.taken && !s_q.priority_levels_on;
    endsequence

    sequence s_take_low;
        clk_en && take.taken && s_q.priority_levels_on && !take.taken_high && !bus.wr;
    endsequence

    sequence s_read_f0;
        clk_en && bus.rd && (bus.addr == `IEFB_OFF_FLAGS0) ##1 1'b1;
    endsequence

    property p_gie_clr_plain;
        s_take_plain |=> !s_q.global_high_enable;
    endproperty
    a_gie_clr_plain: assert property (p_gie_clr_plain) else $error("enable kept after entry"); // R2

    property p_gie_clr_high;
        clk_en && take.taken && s_q.priority_levels_on && take.taken_high
            |=> !s_q.global_high_enable;
    endproperty
    a_gie_clr_high: assert property (p_gie_clr_high) else $error("high enable kept"); // R1

    property p_low_entry;
        s_take_low |=> !s_q.periph_low_enable && (s_q.global_high_enable ==
                                                  $past(s_q.global_high_enable));
    endproperty
    a_low_entry: assert property (p_low_entry) else $error("low entry clear wrong"); // R3

    property p_periph_gate;
        !s_q.priority_levels_on && !s_q.periph_low_enable
            |-> req.req_high == (s_q.global_high_enable && (|pending[7:0]));
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral gate wrong"); // R4

    property p_two_level;
        s_q.priority_levels_on
            |-> req.req_high == (s_q.global_high_enable && (|(pending & src_high_prio)));
    endproperty
    a_two_level: assert property (p_two_level) else $error("two-level split wrong"); // R5

    property p_ext_flag;
        clk_en && ext_hit[0] |=> s_q.irq_flags_0[0];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external flag missed"); // R11

    property p_set_wins;
        clk_en && evt.timer0_ovf && wr0 && !bus.wdata[5] |=> s_q.irq_flags_0[5];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R26

    property p_timer_hold;
        clk_en && s_q.irq_flags_0[5] && !(wr0 && !bus.wdata[5]) |=> s_q.irq_flags_0[5];
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer flag dropped"); // R9

    property p_pin_change_ro;
        s_read_f0 |-> rdata[`IEFB_BIT_PINCHG] == $past(evt.pin_change_pending);
    endproperty
    a_pin_change_ro: assert property (p_pin_change_ro) else $error("pin change bit"); // R10

    property p_csw_no_wake;
        (pending == (32'h1 << `IEFB_SRC_CSW)) |-> !req.wake;
    endproperty
    a_csw_no_wake: assert property (p_csw_no_wake) else $error("switch ready woke"); // R16

    property p_rx_ro;
        clk_en && bus.rd && (bus.addr == `IEFB_OFF_FLAGS3)
            |=> rdata[7] == $past(evt.uart_rx_full[1]) && rdata[4] == $past(evt.uart_tx_empty[0]);
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("uart flag view wrong"); // R22 R23

endmodule
